// file: design/dac_link_consts.svh
// Constants for the serial DAC input latch link
`ifndef DAC_LINK_CONSTS_SVH
`define DAC_LINK_CONSTS_SVH
`define WORD_BITS 16
`define CNT_BITS 5
`define MID_16 16'h8000
`define MID_14 16'h8000
`define MID_12 16'h8000
`define ZERO_CODE 16'h0000
`define SEG_MSBS 4
`define SEG_COUNT 15
`define CLR_MIN_NS 10
`define CLK_SYS_NS 5
`define CLR_CYCLES ((`CLR_MIN_NS + `CLK_SYS_NS - 1) / `CLK_SYS_NS)
`define SCLK_DIV 5
`endif

// file: design/dac_link_pkg.sv
// Types shared by both ends of the serial DAC link
package dac_link_pkg;
    typedef logic [15:0] word_t;
    typedef enum logic [1:0] {RES_16, RES_14, RES_12} res_e;
endpackage

// file: design/dac_link_if.sv
// Three-wire serial link plus clear line between host and DAC
`timescale 1ns/100ps
interface dac_link_if;
    logic sclk;
    logic cs_n;
    logic din;
    logic async_zeroing_n;
    modport host (output sclk, output cs_n, output din, output async_zeroing_n);
    modport dac (input sclk, input cs_n, input din, input async_zeroing_n);
endinterface // dac_link_if

// file: design/dac_input_latch.sv
// DAC end: serial shift register, DAC latch and segment decode
`timescale 1ns/100ps
`include "dac_link_consts.svh"
module dac_input_latch #(
    parameter bit BIPOLAR = 1'b0,
    parameter dac_link_pkg::res_e RES = dac_link_pkg::RES_16
) (
    dac_link_if.dac link,
    input wire logic clk_sys,
    input wire logic rst_n,
    output logic [15:0] code,
    output logic [14:0] segments,
    output logic [11:0] binary_bits,
    output logic zero_volts,
    output logic short_frame
);
    import dac_link_pkg::*;

    // Reset code: midscale for a bipolar part, zero in unipolar use
    localparam word_t RST_CODE = BIPOLAR ? `MID_16 : `ZERO_CODE;
    // Fillers below the code are dropped from the output code
    localparam word_t RES_MASK = (RES == RES_14) ? 16'hfffc :
                                 (RES == RES_12) ? 16'hfff0 : 16'hffff;

    // Link domain: shift register resets while select is high, so no clock is
    // needed outside a frame
    word_t shift_r, shift_nxt;
    logic frame_clr_n;
    assign frame_clr_n = ~link.cs_n;

    always_comb begin
        // Cleared between frames, so no stale bits leak into the next word
        shift_nxt = {shift_r[14:0], link.din};
    end

    always_ff @(posedge link.sclk or negedge frame_clr_n) begin
        if (!frame_clr_n) begin
            shift_r <= 16'h0000;
        end else begin
            shift_r <= shift_nxt;
        end
    end

    // Edge count saturates at sixteen; only a full word matters
    // Five bits hold sixteen without wrapping
    logic [`CNT_BITS-1:0] cnt_r, cnt_nxt;

    always_comb begin
        cnt_nxt = (cnt_r == 5'h10) ? cnt_r : cnt_r + 5'h01;
    end

    always_ff @(posedge link.sclk or negedge frame_clr_n) begin
        if (!frame_clr_n) begin
            cnt_r <= 5'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Latch loads on select rising edge; clear and reset act asynchronously
    // Select itself clocks the latch, since the link clock stops after a frame
    logic latch_rst_n;
    word_t latch_r, latch_nxt;
    logic short_r, short_nxt;
    // Power-on and clear share one asynchronous path
    assign latch_rst_n = rst_n & link.async_zeroing_n;

    always_comb begin
        // Only the last sixteen shifted bits survive a long frame
        latch_nxt = shift_r;
        // A short frame leaves a partial word the host must send again
        short_nxt = (cnt_r != 5'h10);
    end

    always_ff @(posedge link.cs_n or negedge latch_rst_n) begin
        if (!latch_rst_n) begin
            latch_r <= RST_CODE;
            short_r <= 1'b0;
        end else begin
            latch_r <= latch_nxt;
            short_r <= short_nxt;
        end
    end

    // Bring latch into system domain; it only changes at frame end or on a clear, so a
    // three-stage capture with a stability check avoids torn words
    // Limitation: frames closer than a few system cycles would not settle
    word_t sync1_r, sync1_nxt, sync2_r, sync2_nxt, sync3_r, sync3_nxt;

    always_comb begin
        sync1_nxt = latch_r;
        sync2_nxt = sync1_r;
        sync3_nxt = sync2_r;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 16'h0000;
            sync2_r <= 16'h0000;
            sync3_r <= 16'h0000;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            sync3_r <= sync3_nxt;
        end
    end

    // Short-frame flag crosses on its own three flops
    // Trade-off: it may lead the code by a cycle, but keeps the word path plain
    logic sh1_r, sh1_nxt, sh2_r, sh2_nxt, short_o_r, short_o_nxt;

    always_comb begin
        sh1_nxt = short_r;
        sh2_nxt = sh1_r;
        short_o_nxt = sh2_r;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sh1_r <= 1'b0;
            sh2_r <= 1'b0;
            short_o_r <= 1'b0;
        end else begin
            sh1_r <= sh1_nxt;
            sh2_r <= sh2_nxt;
            short_o_r <= short_o_nxt;
        end
    end

    // Settled code, masked to the resolution in use
    // Fillers forced to zero so every variant shows a clean code
    word_t code_r, code_nxt;
    logic [11:0] bin_r, bin_nxt;

    always_comb begin
        // Hold the old code while the two samples disagree
        code_nxt = (sync2_r == sync3_r) ? (sync2_r & RES_MASK) : code_r;
        bin_nxt = code_nxt[11:0];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            code_r <= 16'h0000;
            bin_r <= 12'h000;
        end else begin
            code_r <= code_nxt;
            bin_r <= bin_nxt;
        end
    end

    // Zero-volt indicator follows the code in the same cycle
    logic zv_r, zv_nxt;

    always_comb begin
        // Straight binary zero is all zeros, offset binary zero is midscale
        zv_nxt = BIPOLAR ? (code_nxt == `MID_16) : (code_nxt == `ZERO_CODE);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            zv_r <= 1'b0;
        end else begin
            zv_r <= zv_nxt;
        end
    end

    // Segment decode: one comparator per segment, all equally weighted
    // Decoded from the next code so segments and code change together
    logic [14:0] seg_r, seg_nxt;
    wire [14:0] seg_dec;

    for (genvar g = 0; g < `SEG_COUNT; g++) begin : seg_gen
        assign seg_dec[g] = (code_nxt[15:12] > 4'(g));
    end

    always_comb begin
        seg_nxt = seg_dec;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            seg_r <= 15'h0000;
        end else begin
            seg_r <= seg_nxt;
        end
    end

    assign code = code_r;
    assign segments = seg_r;
    assign binary_bits = bin_r;
    assign zero_volts = zv_r;
    assign short_frame = short_o_r;
endmodule // dac_input_latch

// file: design/dac_host_master.sv
// Host end: serial master that sends one 16-bit word per request
`timescale 1ns/100ps
`include "dac_link_consts.svh"
module dac_host_master (
    dac_link_if.host link,
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic req,
    input wire dac_link_pkg::word_t req_word,
    input wire logic clear_req,
    output logic busy,
    output logic done
);
    import dac_link_pkg::*;

    typedef enum {IDLE, SETUP, LOW, HIGH, FINISH, GAP} state_e;
    state_e st_r, st_nxt;
    word_t sh_r, sh_nxt;
    logic [4:0] bit_r, bit_nxt;
    logic [2:0] div_r, div_nxt;
    logic [1:0] clr_r, clr_nxt;
    logic sclk_r, sclk_nxt, cs_r, cs_nxt, din_r, din_nxt, zn_r, zn_nxt;
    logic busy_r, busy_nxt, done_r, done_nxt;
    logic tick;

    assign tick = (div_r == 3'(`SCLK_DIV - 1));

    always_comb begin
        st_nxt = st_r;
        sh_nxt = sh_r;
        bit_nxt = bit_r;
        div_nxt = tick ? 3'h0 : div_r + 3'h1;
        sclk_nxt = sclk_r;
        cs_nxt = cs_r;
        din_nxt = din_r;
        done_nxt = 1'b0;
        // Clear pulse stretched to the least width
        clr_nxt = clear_req ? 2'(`CLR_CYCLES) : (clr_r != 2'h0 ? clr_r - 2'h1 : clr_r);
        zn_nxt = !(clear_req || clr_r > 2'h1);
        unique case (st_r)
            IDLE: if (req) begin
                sh_nxt = req_word;
                bit_nxt = 5'h00;
                div_nxt = 3'h0;
                cs_nxt = 1'b0;
                st_nxt = SETUP;
            end
            SETUP: if (tick) begin
                din_nxt = sh_r[15];
                sh_nxt = {sh_r[14:0], 1'b0};
                st_nxt = LOW;
            end
            LOW: if (tick) begin
                sclk_nxt = 1'b1;
                bit_nxt = bit_r + 5'h01;
                st_nxt = HIGH;
            end
            HIGH: if (tick) begin
                sclk_nxt = 1'b0;
                if (bit_r == 5'h10) begin
                    st_nxt = FINISH;
                end else begin
                    din_nxt = sh_r[15];
                    sh_nxt = {sh_r[14:0], 1'b0};
                    st_nxt = LOW;
                end
            end
            FINISH: if (tick) begin
                cs_nxt = 1'b1;
                done_nxt = 1'b1;
                st_nxt = GAP;
            end
            GAP: if (tick) begin
                st_nxt = IDLE;
            end
        endcase
        busy_nxt = (st_nxt != IDLE);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= IDLE;
            sh_r <= 16'h0000;
            bit_r <= 5'h00;
            div_r <= 3'h0;
            clr_r <= 2'h0;
            sclk_r <= 1'b0;
            cs_r <= 1'b1;
            din_r <= 1'b0;
            zn_r <= 1'b1;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            sh_r <= sh_nxt;
            bit_r <= bit_nxt;
            div_r <= div_nxt;
            clr_r <= clr_nxt;
            sclk_r <= sclk_nxt;
            cs_r <= cs_nxt;
            din_r <= din_nxt;
            zn_r <= zn_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign link.sclk = sclk_r;
    assign link.cs_n = cs_r;
    assign link.din = din_r;
    assign link.async_zeroing_n = zn_r;
    assign busy = busy_r;
    assign done = done_r;
endmodule // dac_host_master

// file: tb/dac_link_monitor.sv
// Protocol checker watching the serial DAC link signals
`timescale 1ns/100ps
module dac_link_monitor (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic async_zeroing_n
);
    logic sclk_d_r;
    logic sclk_d_nxt;
    logic [4:0] edges_r;
    logic [4:0] edges_nxt;
    // Counts rising edges of sclk within one frame
    always_comb begin
        sclk_d_nxt = sclk;
        edges_nxt = cs_n ? 5'h00 : edges_r + {4'h0, sclk & ~sclk_d_r};
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d_r <= 1'b0;
            edges_r <= 5'h00;
        end else begin
            sclk_d_r <= sclk_d_nxt;
            edges_r <= edges_nxt;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    idle_clock_a: assert property (cs_n |-> !sclk)
        else $error("sclk toggles outside a frame");
    select_lead_a: assert property ($fell(cs_n) |-> !sclk [*8])
        else $error("sclk rises too soon after select");
    clock_high_a: assert property ($rose(sclk) |-> sclk [*5] ##1 !sclk)
        else $error("sclk high phase not five cycles");
    data_steady_a: assert property (sclk |-> $stable(din))
        else $error("din moves while sclk high");
    frame_edges_a: assert property ($rose(cs_n) |-> edges_r == 5'h10)
        else $error("frame without sixteen edges");
    frame_bound_a: assert property ($fell(cs_n) |-> ##[150:200] $rose(cs_n))
        else $error("frame length out of range");
    select_gap_a: assert property ($rose(cs_n) |-> cs_n [*2])
        else $error("select high gap too short");
    clear_width_a: assert property ($fell(async_zeroing_n) |-> !async_zeroing_n [*2])
        else $error("clear pulse shorter than two cycles");
    frame_c: cover property ($rose(cs_n));
    clear_c: cover property ($fell(async_zeroing_n));
    edge_c: cover property ($rose(sclk) && !din);
endmodule // dac_link_monitor

// file: tb/testbench.sv
// Host and DAC ends joined over the link, with self-checking tests
`timescale 1ns/100ps
module testbench;
    import dac_link_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b1;
    logic req = 1'b0;
    word_t req_word = 16'h0000;
    logic clear_req = 1'b0;
    logic busy, done, zero_volts, short_frame, zero_b;
    word_t code, code_b, code_c;
    logic [14:0] segments;
    logic [11:0] binary_bits;
    int failures = 0;
    int checked = 0;
    always #2.5 clk_sys = ~clk_sys;
    dac_link_if dac_link_if_i ();
    dac_host_master dac_host_master_i (.link(dac_link_if_i.host), .clk_sys(clk_sys),
        .rst_n(rst_n), .req(req), .req_word(req_word), .clear_req(clear_req),
        .busy(busy), .done(done));
    dac_input_latch dac_input_latch_i (.link(dac_link_if_i.dac), .clk_sys(clk_sys),
        .rst_n(rst_n), .code(code), .segments(segments), .binary_bits(binary_bits),
        .zero_volts(zero_volts), .short_frame(short_frame));
    // Bipolar twelve-bit end shares the same link
    dac_input_latch #(.BIPOLAR(1'b1), .RES(RES_12)) dac_input_latch_i2 (
        .link(dac_link_if_i.dac), .clk_sys(clk_sys), .rst_n(rst_n), .code(code_b),
        .segments(), .binary_bits(), .zero_volts(zero_b), .short_frame());
    // Unipolar fourteen-bit end on the same link
    dac_input_latch #(.BIPOLAR(1'b0), .RES(RES_14)) dac_input_latch_i3 (
        .link(dac_link_if_i.dac), .clk_sys(clk_sys), .rst_n(rst_n), .code(code_c),
        .segments(), .binary_bits(), .zero_volts(), .short_frame());
    dac_link_monitor dac_link_monitor_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .sclk(dac_link_if_i.sclk), .cs_n(dac_link_if_i.cs_n), .din(dac_link_if_i.din),
        .async_zeroing_n(dac_link_if_i.async_zeroing_n));
    task automatic check(input word_t seen, input word_t exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic word_t thermo(input word_t w);
        word_t t;
        t = 16'h0000;
        for (int i = 0; i < 15; i++) t[i] = (w[15:12] > i);
        return t;
    endfunction
    task automatic tally_and_finish();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic send(input word_t w);
        int n;
        n = 0;
        @(negedge clk_sys);
        req = 1'b1;
        req_word = w;
        @(negedge clk_sys);
        req = 1'b0;
        check({15'h0, busy}, 16'h0001);
        while (done !== 1'b1 && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 400) check(16'hdead, 16'h0000);
        repeat (10) @(negedge clk_sys);
        check({15'h0, busy}, 16'h0000);
    endtask
    task automatic t_reset();
        check(code, 16'h0000);
        check(code_b, 16'h8000);
        check(code_c, 16'h0000);
        check({15'h0, zero_volts}, 16'h0001);
        check({15'h0, zero_b}, 16'h0001);
        $display("test reset done");
    endtask
    task automatic t_words();
        word_t tbl[4] = '{16'ha5c3, 16'hffff, 16'h0001, 16'h8000};
        foreach (tbl[k]) begin
            send(tbl[k]);
            check(code, tbl[k]);
            check(code_b, tbl[k] & 16'hfff0);
            check(code_c, tbl[k] & 16'hfffc);
            check({15'h0, zero_volts}, {15'h0, tbl[k] == 16'h0000});
            check({1'b0, segments}, thermo(tbl[k]));
            check({4'h0, binary_bits}, {4'h0, tbl[k][11:0]});
            check({15'h0, short_frame}, 16'h0000);
            check({15'h0, zero_b}, {15'h0, tbl[k] == 16'h8000});
        end
        repeat (50) @(negedge clk_sys);
        check(code, 16'h8000);
        $display("test words done");
    endtask
    task automatic t_clear();
        send(16'h1234);
        check(code_b, 16'h1230);
        clear_req = 1'b1;
        @(negedge clk_sys);
        clear_req = 1'b0;
        repeat (12) @(negedge clk_sys);
        check(code, 16'h0000);
        check(code_c, 16'h0000);
        check(code_b, 16'h8000);
        $display("test clear done");
    endtask
    initial begin
        // Reset falls after time zero so every asynchronous reset sees the edge
        @(negedge clk_sys);
        rst_n = 1'b0;
        repeat (12) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (10) @(negedge clk_sys);
        t_reset();
        t_words();
        t_clear();
        tally_and_finish();
    end
    // Whole run needs about 1000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        tally_and_finish();
    end
endmodule // testbench
